// ---- hw/bcd_time_calendar_counter.sv ----
// BCD time-of-day and calendar counter with crystal trimming and oscillator-halt flag.
// Assumes a register port in the reference clock domain and a free-running crystal
// clock that is sampled by the reference clock.
`timescale 1ns/1ps

// Overview of operation
// RQ1 - Seconds count BCD 00 to 59; wrap from 59 carries into minutes.
// RQ2 - Minutes count BCD 00 to 59; wrap from 59 carries into hours.
// RQ3 - Hour rollover 11 p.m. to 12 a.m. or 23 to 00 advances day and weekday.
// RQ4 - Address 0 holds seconds tens in bits 6-4, units 3-0; bit 7 reads zero.
// RQ5 - Address 1 holds minutes tens in bits 6-4, units 3-0; bit 7 reads zero.
// RQ6 - Address 2 holds PM flag or hour tens bit 5, tens bit 4, units 3-0.
// RQ7 - After power-up digit fields are undefined; always-zero bits still read zero.
// RQ8 - Weekday advances by one on every carry from hours into the day.
// RQ9 - Weekday code counts modulo seven, Sunday 000 to Saturday 110.
// RQ10 - Address 3 holds weekday code in bits 2-0; upper bits read zero.
// RQ11 - Host never writes weekday code 111.
// RQ12 - Day counts 1 to 31, or 30 in short months, then wraps and carries.
// RQ13 - February wraps after 29 in leap years, after 28 otherwise.
// RQ14 - Month counts 1 to 12; wrap from 12 carries into the year.
// RQ15 - Year counts 00 to 99; every multiple of four is a leap year.
// RQ16 - Host replaces nonexistent time or date values with valid ones.
// RQ17 - Address 4 holds day tens in bits 5-4, units 3-0; bits 7-6 zero.
// RQ18 - Address 5 holds month tens in bit 4, units 3-0; bits 7-5 zero.
// RQ19 - Address 6 holds year tens in bits 7-4 and units in 3-0.
// RQ20 - Address 7 holds crystal select bit 7, trim 6-0; zero after power-up.
// RQ21 - Crystal select clear means 32.768 kHz, set means 32 kHz.
// RQ22 - A second takes 32768 or 32000 cycles; trim only at 00, 20, 40.
// RQ23 - Trim adds (value-1)*2 cycles, or subtracts (~value+1)*2 with direction set.
// RQ24 - Oscillator-halt flag records a stopped oscillator and invalid clock data.
// RQ25 - Twelve-hour mode uses bit 5 as PM, hours 12,1..11; else bit 5 is tens.
// RQ26 - Register writes load the counter directly; counting resumes at next tick.
module bcd_time_calendar_counter
  import rtc_calendar_pkg::*;
#(
  parameter int OSC_TIMEOUT = rtc_calendar_pkg::OSC_TIMEOUT_CYCLES,
  // Crystal cycles per second; a bench may shorten them to keep a run brief
  parameter logic [15:0] CYCLES_MAIN = rtc_calendar_pkg::CYCLES_32768,
  parameter logic [15:0] CYCLES_ALT = rtc_calendar_pkg::CYCLES_32000
)
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // Crystal oscillator clock
  input wire logic osc_clk_i,
  // Register port
  input wire rtc_calendar_pkg::reg_req_t reg_req_i,
  output logic [7:0] rdata_o,
  // Control from the surrounding control logic
  input wire logic hour_mode_24_i,
  input wire logic osc_halt_clear_i,
  // Status
  output logic osc_halt_flag_o,
  output logic second_tick_o,
  output rtc_calendar_pkg::calendar_t time_o
);
  import rtc_calendar_pkg::*;

  localparam logic [15:0] TIMEOUT_CYCLES = 16'(OSC_TIMEOUT);

  // BCD increment with wrap from hi back to lo
  function automatic logic [7:0] bcd_step(input logic [7:0] v, input logic [7:0] lo,
                                          input logic [7:0] hi);
    logic [7:0] r;
    r = v;
    if (v == hi)
    begin
      r = lo;
    end
    else if (v[3:0] == 4'h9)
    begin
      r = {v[7:4] + 4'h1, 4'h0};
    end
    else
    begin
      r = {v[7:4], v[3:0] + 4'h1};
    end
    return r;
  endfunction

  // Next hour value in either display mode
  function automatic logic [7:0] hour_step(input logic [7:0] h, input logic mode24);
    logic [7:0] hr;
    logic [7:0] r;
    hr = {3'b000, h[4:0]};
    r = h;
    if (mode24)
    begin
      r = bcd_step(h, BCD_00, BCD_23);
    end
    else if (hr == BCD_12)
    begin
      r = {h[7:5], 5'h01};
    end
    else if (hr == BCD_11)
    begin
      r = {h[7:6], ~h[HOUR_PM_BIT], 5'h12};
    end
    else
    begin
      r = {h[7:5], 5'(bcd_step(hr, BCD_01, BCD_12))};
    end
    return r;
  endfunction

  // Leap year: BCD year divisible by four, 00 included
  function automatic logic is_leap(input logic [7:0] y);
    logic [1:0] rem;
    rem = y[1:0] + {y[4], 1'b0};
    return rem == 2'b00;
  endfunction

  // Last day of the month in BCD
  function automatic logic [7:0] month_last_day(input logic [7:0] m, input logic [7:0] y);
    logic [7:0] r;
    case (m)
      BCD_02: r = is_leap(y) ? BCD_29 : BCD_28;
      BCD_04, BCD_06, BCD_09, BCD_11: r = BCD_30;
      default: r = BCD_31;
    endcase
    return r;
  endfunction

  calendar_t cal_reg;
  calendar_t cal_next;
  calendar_t cal_count;
  logic osc_sync1_reg;
  logic osc_sync2_reg;
  logic osc_prev_reg;
  logic [15:0] div_reg;
  logic [15:0] div_next;
  logic [15:0] idle_reg;
  logic [15:0] idle_next;
  logic halt_reg;
  logic halt_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic tick_reg;

  // Crystal edge detection on the synchronised copy
  wire osc_rise = osc_sync2_reg & ~osc_prev_reg;

  // Seconds length including trimming
  wire [5:0] trim_value = cal_reg.trim[TRIM_VALUE_LSB +: 6];
  wire trim_dir = cal_reg.trim[TRIM_DIRECTION_BIT];
  wire [15:0] base_cycles = cal_reg.trim[CRYSTAL_SELECT_BIT] ? CYCLES_ALT : CYCLES_MAIN; // RQ21
  wire [15:0] trim_add = {9'h000, trim_value - 6'h01, 1'b0}; // RQ23
  wire [15:0] trim_sub = {8'h00, 7'({1'b0, ~trim_value} + 7'h01), 1'b0}; // RQ23
  wire trim_noop = trim_value[5:1] == 5'h00;
  wire trim_second = (cal_reg.seconds == BCD_00) | (cal_reg.seconds == BCD_20)
                     | (cal_reg.seconds == BCD_40);
  wire trim_active = trim_second & ~trim_noop; // RQ22
  wire [15:0] trimmed_cycles = trim_dir ? base_cycles - trim_sub : base_cycles + trim_add;
  wire [15:0] second_cycles = trim_active ? trimmed_cycles : base_cycles; // RQ22
  // At or past the end, so shortening a second mid-count cannot send the divider round
  wire div_last = div_reg >= second_cycles - 16'h0001;
  wire tick = osc_rise & div_last;

  // Carry chain
  wire sec_carry = tick & (cal_reg.seconds == BCD_59); // RQ1
  wire min_carry = sec_carry & (cal_reg.minutes == BCD_59); // RQ2
  wire hour_at_end = hour_mode_24_i ? (cal_reg.hours == BCD_23)
                     : (cal_reg.hours == {2'b00, 1'b1, 5'h11});
  wire day_carry = min_carry & hour_at_end; // RQ3
  wire [7:0] last_day = month_last_day(cal_reg.month, cal_reg.year); // RQ12 RQ13
  wire month_carry = day_carry & (cal_reg.day == last_day);
  wire year_carry = month_carry & (cal_reg.month == BCD_12); // RQ14
  wire [2:0] weekday_now = cal_reg.weekday[2:0];
  // A stray code 111 falls back to Sunday; the host is expected never to write it
  wire [2:0] weekday_inc = (weekday_now == WEEKDAY_LAST) ? 3'h0 : weekday_now + 3'h1; // RQ9 RQ11

  // Writes
  wire wr = reg_req_i.wr;
  wire [3:0] waddr = reg_req_i.addr;
  wire [7:0] wdata = reg_req_i.data;

  // Counting, then register writes take precedence for the addressed field
  always_comb
  begin
    cal_count = cal_reg;
    if (tick)
    begin
      cal_count.seconds = bcd_step(cal_reg.seconds, BCD_00, BCD_59); // RQ1
    end
    if (sec_carry)
    begin
      cal_count.minutes = bcd_step(cal_reg.minutes, BCD_00, BCD_59); // RQ2
    end
    if (min_carry)
    begin
      cal_count.hours = hour_step(cal_reg.hours, hour_mode_24_i); // RQ25
    end
    if (day_carry)
    begin
      cal_count.day = bcd_step(cal_reg.day, BCD_01, last_day); // RQ12 RQ13
      cal_count.weekday = {5'h00, weekday_inc}; // RQ8
    end
    if (month_carry)
    begin
      cal_count.month = bcd_step(cal_reg.month, BCD_01, BCD_12); // RQ14
    end
    if (year_carry)
    begin
      cal_count.year = bcd_step(cal_reg.year, BCD_00, BCD_99); // RQ15
    end
  end

  always_comb
  begin
    cal_next = cal_count;
    if (wr)
    begin
      case (waddr)
        ADDR_SECONDS: cal_next.seconds = wdata & MASK_SECONDS; // RQ4 RQ26
        ADDR_MINUTES: cal_next.minutes = wdata & MASK_MINUTES; // RQ5 RQ26
        ADDR_HOURS: cal_next.hours = wdata & MASK_HOURS; // RQ6 RQ26
        ADDR_WEEKDAY: cal_next.weekday = wdata & MASK_WEEKDAY; // RQ10 RQ26
        ADDR_DAY: cal_next.day = wdata & MASK_DAY; // RQ17 RQ26
        ADDR_MONTH: cal_next.month = wdata & MASK_MONTH; // RQ18 RQ26
        ADDR_YEAR: cal_next.year = wdata & MASK_YEAR; // RQ19 RQ26
        ADDR_TRIM: cal_next.trim = wdata & MASK_TRIM; // RQ20
        default: cal_next = cal_count;
      endcase
    end
  end

  // Read mux; addresses above 7 read as zero
  always_comb
  begin
    case (reg_req_i.addr)
      ADDR_SECONDS: rdata_next = cal_reg.seconds & MASK_SECONDS; // RQ4
      ADDR_MINUTES: rdata_next = cal_reg.minutes & MASK_MINUTES; // RQ5
      ADDR_HOURS: rdata_next = cal_reg.hours & MASK_HOURS; // RQ6
      ADDR_WEEKDAY: rdata_next = cal_reg.weekday & MASK_WEEKDAY; // RQ10
      ADDR_DAY: rdata_next = cal_reg.day & MASK_DAY; // RQ17
      ADDR_MONTH: rdata_next = cal_reg.month & MASK_MONTH; // RQ18
      ADDR_YEAR: rdata_next = cal_reg.year & MASK_YEAR; // RQ19
      ADDR_TRIM: rdata_next = cal_reg.trim & MASK_TRIM; // RQ20
      default: rdata_next = 8'h00;
    endcase
  end

  // Second divider restarts on each tick
  assign div_next = osc_rise ? (div_last ? 16'h0000 : div_reg + 16'h0001) : div_reg;

  // Halt watchdog counts reference cycles without a crystal edge
  wire idle_expired = idle_reg == TIMEOUT_CYCLES;
  assign idle_next = osc_rise ? 16'h0000 : (idle_expired ? idle_reg : idle_reg + 16'h0001);

  // Set wins over a clear in the same cycle, so a stop is never missed
  assign halt_next = idle_expired | (halt_reg & ~osc_halt_clear_i); // RQ24

  // Crystal synchroniser; the first stage feeds only the second
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      osc_sync1_reg <= 1'b0;
      osc_sync2_reg <= 1'b0;
      osc_prev_reg <= 1'b0;
    end
    else
    begin
      osc_sync1_reg <= osc_clk_i;
      osc_sync2_reg <= osc_sync1_reg;
      osc_prev_reg <= osc_sync2_reg;
    end
  end

  // Power-up state: time and date fields are undefined to the host, trim reads zero
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cal_reg <= '{seconds: RESET_TIME, minutes: RESET_TIME, hours: RESET_TIME,
                   weekday: RESET_TIME, day: RESET_DATE, month: RESET_DATE,
                   year: RESET_TIME, trim: RESET_TRIM}; // RQ7 RQ20
    end
    else
    begin
      cal_reg <= cal_next;
    end
  end

  // Second divider
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      div_reg <= 16'h0000;
    end
    else
    begin
      div_reg <= div_next;
    end
  end

  // Halt watchdog
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      idle_reg <= 16'h0000;
    end
    else
    begin
      idle_reg <= idle_next;
    end
  end

  // Power-up counts as a halt, so the host sees the data as invalid
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      halt_reg <= 1'b1; // RQ24
    end
    else
    begin
      halt_reg <= halt_next;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rdata_reg <= 8'h00;
    end
    else
    begin
      rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      tick_reg <= 1'b0;
    end
    else
    begin
      tick_reg <= tick;
    end
  end

  assign rdata_o = rdata_reg;
  assign osc_halt_flag_o = halt_reg;
  assign second_tick_o = tick_reg;
  assign time_o = cal_reg;

endmodule

// ---- hw/rtc_calendar_pkg.sv ----
// Constants, field layouts and carrier types for the BCD time and calendar counter.
// Assumes a 50 MHz reference clock and a crystal clock sampled as an ordinary input.
package rtc_calendar_pkg;

  // Register addresses on the internal register port
  localparam logic [3:0] ADDR_SECONDS = 4'h0;
  localparam logic [3:0] ADDR_MINUTES = 4'h1;
  localparam logic [3:0] ADDR_HOURS = 4'h2;
  localparam logic [3:0] ADDR_WEEKDAY = 4'h3;
  localparam logic [3:0] ADDR_DAY = 4'h4;
  localparam logic [3:0] ADDR_MONTH = 4'h5;
  localparam logic [3:0] ADDR_YEAR = 4'h6;
  localparam logic [3:0] ADDR_TRIM = 4'h7;

  // Implemented bits of each register; the rest read as zero
  localparam logic [7:0] MASK_SECONDS = 8'h7F;
  localparam logic [7:0] MASK_MINUTES = 8'h7F;
  localparam logic [7:0] MASK_HOURS = 8'h3F;
  localparam logic [7:0] MASK_WEEKDAY = 8'h07;
  localparam logic [7:0] MASK_DAY = 8'h3F;
  localparam logic [7:0] MASK_MONTH = 8'h1F;
  localparam logic [7:0] MASK_YEAR = 8'hFF;
  localparam logic [7:0] MASK_TRIM = 8'hFF;

  // Field positions
  localparam int HOUR_PM_BIT = 5;
  localparam int CRYSTAL_SELECT_BIT = 7;
  localparam int TRIM_DIRECTION_BIT = 6;
  localparam int TRIM_VALUE_LSB = 0;

  // Reset values after a power-up from zero volts
  localparam logic [7:0] RESET_TIME = 8'h00;
  localparam logic [7:0] RESET_DATE = 8'h01;
  localparam logic [7:0] RESET_TRIM = 8'h00;

  // BCD limits
  localparam logic [7:0] BCD_00 = 8'h00;
  localparam logic [7:0] BCD_01 = 8'h01;
  localparam logic [7:0] BCD_02 = 8'h02;
  localparam logic [7:0] BCD_04 = 8'h04;
  localparam logic [7:0] BCD_06 = 8'h06;
  localparam logic [7:0] BCD_09 = 8'h09;
  localparam logic [7:0] BCD_11 = 8'h11;
  localparam logic [7:0] BCD_12 = 8'h12;
  localparam logic [7:0] BCD_20 = 8'h20;
  localparam logic [7:0] BCD_23 = 8'h23;
  localparam logic [7:0] BCD_28 = 8'h28;
  localparam logic [7:0] BCD_29 = 8'h29;
  localparam logic [7:0] BCD_30 = 8'h30;
  localparam logic [7:0] BCD_31 = 8'h31;
  localparam logic [7:0] BCD_40 = 8'h40;
  localparam logic [7:0] BCD_59 = 8'h59;
  localparam logic [7:0] BCD_99 = 8'h99;
  localparam logic [2:0] WEEKDAY_LAST = 3'h6;

  // Crystal cycles per second
  localparam logic [15:0] CYCLES_32768 = 16'h8000;
  localparam logic [15:0] CYCLES_32000 = 16'h7D00;

  // Oscillator-halt detection: no crystal edge for this long sets the halt flag
  localparam int REF_PERIOD_NS = 20;
  localparam int OSC_TIMEOUT_NS = 100000;
  localparam int OSC_TIMEOUT_CYCLES = OSC_TIMEOUT_NS / REF_PERIOD_NS;

  // One register-port request
  typedef struct packed {
    logic wr;
    logic [3:0] addr;
    logic [7:0] data;
  } reg_req_t;

  // Complete time, calendar and trim state
  typedef struct packed {
    logic [7:0] seconds;
    logic [7:0] minutes;
    logic [7:0] hours;
    logic [7:0] weekday;
    logic [7:0] day;
    logic [7:0] month;
    logic [7:0] year;
    logic [7:0] trim;
  } calendar_t;

endpackage

// ---- tb/bcd_time_calendar_counter_tb_top.sv ----
// Self-checking bench for the calendar counter.
// Inputs change at falling edges; crystal comes from xtal_model.
`timescale 1ns/1ps
module bcd_time_calendar_counter_tb_top;
  import rtc_calendar_pkg::*;
  // Scaled second lengths keep the run short; trim arithmetic is unchanged
  localparam logic [15:0] SCALED_MAIN = 16'h0200;
  localparam logic [15:0] SCALED_ALT = 16'h01F4;
  logic ref_clk_i;
  logic rstn_i;
  logic run;
  logic osc_clk;
  int rises;
  reg_req_t req;
  logic [7:0] rdata;
  logic mode24;
  logic halt_clr;
  logic halt;
  logic tick;
  calendar_t tm;
  int fail_count;
  int comparisons;
  int cycles;
  int r0;
  bcd_time_calendar_counter #(.OSC_TIMEOUT(64), .CYCLES_MAIN(SCALED_MAIN),
    .CYCLES_ALT(SCALED_ALT)) DUT (.ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i), .osc_clk_i(osc_clk), .reg_req_i(req), .rdata_o(rdata),
    .hour_mode_24_i(mode24), .osc_halt_clear_i(halt_clr), .osc_halt_flag_o(halt),
    .second_tick_o(tick), .time_o(tm));
  xtal_model u_xtal (.run_i(run), .osc_clk_o(osc_clk), .rises_o(rises));
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    req = '{1'b1, a, d};
    @(negedge ref_clk_i);
    req.wr = 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge ref_clk_i);
    req = '{1'b0, a, 8'h00};
    repeat (2) @(negedge ref_clk_i);
    d = rdata;
  endtask
  task automatic wait_tick();
    @(posedge ref_clk_i);
    while (tick !== 1'b1) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
  endtask
  task automatic t_reset();
    logic [7:0] d;
    check("halt", 8'h01, {7'h00, halt});
    check("trim", 8'h00, tm.trim);
    rd(ADDR_HOURS, d);
    check("hours top", 8'h00, {6'h00, d[7:6]});
    halt_clr = 1'b1;
    @(negedge ref_clk_i);
    halt_clr = 1'b0;
    @(negedge ref_clk_i);
    check("halt clear", 8'h00, {7'h00, halt});
  endtask
  task automatic t_regs();
    logic [7:0] d;
    logic [7:0] e [8];
    e = '{8'h76, 8'h76, 8'h36, 8'h06, 8'h36, 8'h16, 8'hF6, 8'hF6};
    for (int a = 0; a < 8; a++)
    begin
      wr(4'(a), 8'hF6);
      rd(4'(a), d);
      check("reg", e[a], d);
    end
  endtask
  // One tick wraps every field, with the 32 kHz crystal selected
  task automatic t_year_wrap();
    int n;
    mode24 = 1'b1;
    wr(ADDR_TRIM, 8'h80);
    wr(ADDR_SECONDS, BCD_59);
    wr(ADDR_MINUTES, BCD_59);
    wr(ADDR_HOURS, BCD_23);
    wr(ADDR_WEEKDAY, 8'h06);
    wr(ADDR_DAY, BCD_31);
    wr(ADDR_MONTH, BCD_12);
    wr(ADDR_YEAR, BCD_99);
    wait_tick();
    n = rises - r0;
    check("rises", 8'h01, {7'h00, n inside {[SCALED_ALT:SCALED_ALT + 2]}});
    check("sec", 8'h00, tm.seconds);
    check("min", 8'h00, tm.minutes);
    check("hour", 8'h00, tm.hours);
    check("wday", 8'h00, tm.weekday);
    check("day", 8'h01, tm.day);
    check("month", 8'h01, tm.month);
    check("year", 8'h00, tm.year);
  endtask
  // Year 00 is leap; 11 PM rolls to 12 AM in twelve-hour mode
  task automatic t_leap_12h();
    mode24 = 1'b0;
    wr(ADDR_SECONDS, BCD_59);
    wr(ADDR_MINUTES, BCD_59);
    wr(ADDR_HOURS, 8'h31);
    wr(ADDR_DAY, BCD_28);
    wr(ADDR_MONTH, BCD_02);
    wait_tick();
    check("hour12", 8'h12, tm.hours);
    check("leap day", BCD_29, tm.day);
    check("feb", BCD_02, tm.month);
    check("wday2", 8'h01, tm.weekday);
  endtask
  // Trim lengthens a 00 second, shortens a 20 second and leaves a 21 second alone
  task automatic t_trim();
    int r1;
    r1 = rises;
    wr(ADDR_TRIM, 8'h29);
    wait_tick();
    check("trim add", 8'h01, {7'h00, rises - r1 == SCALED_MAIN + (41 - 1) * 2});
    r1 = rises;
    // Six-bit value 41 inverted is 22
    wr(ADDR_TRIM, 8'h69);
    wr(ADDR_SECONDS, BCD_20);
    wait_tick();
    check("trim sub", 8'h01, {7'h00, rises - r1 == SCALED_MAIN - (22 + 1) * 2});
    r1 = rises;
    wait_tick();
    check("trim idle", 8'h01, {7'h00, rises - r1 == SCALED_MAIN});
    check("trim sec", 8'h22, tm.seconds);
  endtask
  task automatic t_halt();
    run = 1'b0;
    repeat (100) @(negedge ref_clk_i);
    check("halt stop", 8'h01, {7'h00, halt});
  endtask
  initial
  begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  // Five scaled seconds take about 21k reference cycles
  always @(posedge ref_clk_i)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      fail_count++;
      final_report();
    end
  end
  initial
  begin
    rstn_i = 1'b0;
    run = 1'b1;
    req = '{1'b0, 4'h0, 8'h00};
    mode24 = 1'b1;
    halt_clr = 1'b0;
    repeat (12) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    rstn_i = 1'b1;
    r0 = rises;
    t_reset();
    t_regs();
    t_year_wrap();
    t_leap_12h();
    t_trim();
    t_halt();
    final_report();
  end
endmodule

// ---- tb/cal_chk.sv ----
// Port-level assertions for the calendar counter.
// Assumes one reference clock domain; bound to every counter instance.
`timescale 1ns/1ps
module cal_chk
  import rtc_calendar_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // Observed ports
  input wire rtc_calendar_pkg::reg_req_t reg_req_i,
  input wire logic [7:0] rdata_o,
  input wire logic second_tick_o,
  input wire rtc_calendar_pkg::calendar_t time_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  property p_rd_sec;
    $past(reg_req_i.addr) == ADDR_SECONDS |-> rdata_o[7] == 1'b0;
  endproperty
  a_rd_sec: assert property (p_rd_sec) else $error("seconds top bit set");
  property p_rd_hr;
    $past(reg_req_i.addr) == ADDR_HOURS |-> rdata_o[7:6] == 2'h0;
  endproperty
  a_rd_hr: assert property (p_rd_hr) else $error("hours top bits set");
  property p_rd_wd;
    $past(reg_req_i.addr) == ADDR_WEEKDAY |-> rdata_o[7:3] == 5'h00;
  endproperty
  a_rd_wd: assert property (p_rd_wd) else $error("weekday top bits set");
  property p_rd_mon;
    $past(reg_req_i.addr) == ADDR_MONTH |-> rdata_o[7:5] == 3'h0;
  endproperty
  a_rd_mon: assert property (p_rd_mon) else $error("month top bits set");
  property p_trim_load;
    reg_req_i.wr && reg_req_i.addr == ADDR_TRIM |=> time_o.trim == $past(reg_req_i.data);
  endproperty
  a_trim_load: assert property (p_trim_load) else $error("trim not loaded");
  property p_sec_wrap;
    $past(time_o.seconds) == BCD_59 && $changed(time_o.seconds) && !$past(reg_req_i.wr)
      |-> time_o.seconds == BCD_00 && $changed(time_o.minutes);
  endproperty
  a_sec_wrap: assert property (p_sec_wrap) else $error("seconds wrap wrong");
  property p_min_wrap;
    $past(time_o.minutes) == BCD_59 && $changed(time_o.minutes) && !$past(reg_req_i.wr)
      |-> time_o.minutes == BCD_00 && $changed(time_o.hours);
  endproperty
  a_min_wrap: assert property (p_min_wrap) else $error("minutes wrap wrong");
  property p_wd_step;
    $changed(time_o.weekday) && !$past(reg_req_i.wr) |-> time_o.weekday ==
      (($past(time_o.weekday) == 8'h06) ? 8'h00 : $past(time_o.weekday) + 8'h01);
  endproperty
  a_wd_step: assert property (p_wd_step) else $error("weekday step wrong");
  property p_day_wd;
    $changed(time_o.day) && !$past(reg_req_i.wr) |-> $changed(time_o.weekday);
  endproperty
  a_day_wd: assert property (p_day_wd) else $error("weekday missed day");
  property p_tick_sec;
    $changed(time_o.seconds) && !$past(reg_req_i.wr) |-> second_tick_o;
  endproperty
  a_tick_sec: assert property (p_tick_sec) else $error("seconds moved without tick");
  c_tick: cover property (second_tick_o);
  c_day: cover property ($changed(time_o.day) && !$past(reg_req_i.wr));
  c_trim: cover property (reg_req_i.wr && reg_req_i.addr == ADDR_TRIM);
endmodule
bind bcd_time_calendar_counter cal_chk u_chk (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
  .reg_req_i(reg_req_i), .rdata_o(rdata_o), .second_tick_o(second_tick_o), .time_o(time_o));

// ---- tb/xtal_model.sv ----
// Crystal oscillator model, 160 ns period.
// Stops low while run_i is low so a halted oscillator can be shown.
`timescale 1ns/1ps
module xtal_model (
  // Control
  input wire logic run_i,
  // Crystal output and rise count
  output logic osc_clk_o,
  output int rises_o
);
  initial
  begin
    osc_clk_o = 1'b0;
    rises_o = 0;
    // Edges land between reference clock edges so a sample never races them
    #5;
    forever
    begin
      #80;
      osc_clk_o = run_i ? ~osc_clk_o : 1'b0;
      if (run_i && osc_clk_o)
        rises_o = rises_o + 1;
    end
  end
endmodule
